// [inc/ssm_pkg.sv]
package ssm_pkg;

   // ===========================================
   // register byte addresses (apb, one word each)
   localparam logic [7:0] ADDR_OPMODE     = 8'h00;
   localparam logic [7:0] ADDR_MODCFG     = 8'h04;
   localparam logic [7:0] ADDR_TXCFG      = 8'h08;
   localparam logic [7:0] ADDR_DETTUNE    = 8'h0c;
   localparam logic [7:0] ADDR_DETTHRESH  = 8'h10;
   localparam logic [7:0] ADDR_STATUS     = 8'h14;
   localparam logic [7:0] ADDR_FIFO_DATA  = 8'h18;
   localparam logic [7:0] ADDR_FIFO_PTR   = 8'h1c;
   localparam logic [7:0] ADDR_CONTROL    = 8'h20;
   localparam logic [7:0] ADDR_FSK_CFG    = 8'h04;

   // ===========================================
   // field positions
   localparam int OPM_MODEM_BIT  = 7;
   localparam int OPM_MODE_LSB   = 0;
   localparam int MOD_SF_LSB     = 4;
   localparam int MOD_BW_LSB     = 0;
   localparam int TX_CR_LSB      = 1;
   localparam int TX_IMPL_BIT    = 0;
   localparam int TX_CRHDR_BIT   = 4;

   // ===========================================
   // reset values
   localparam logic [2:0] OPM_MODE_RST   = 3'h1;
   localparam logic [3:0] SF_RST         = 4'h7;
   localparam logic [3:0] BW_RST         = 4'h7;
   localparam logic [2:0] CR_RST         = 3'h1;
   localparam logic [2:0] DETTUNE_RST    = 3'h3;
   localparam logic [7:0] DETTHRESH_RST  = 8'h0a;
   localparam logic [7:0] FSK_CFG_RST    = 8'h00;

   // ===========================================
   // spreading factor, coding rate and bandwidth limits
   localparam logic [3:0] SF_MIN = 4'h6;
   localparam logic [3:0] SF_MAX = 4'hc;
   localparam logic [2:0] CR_MIN = 3'h1;
   localparam logic [2:0] CR_MAX = 3'h4;
   localparam logic [3:0] BW_MAX = 4'h9;

   // operating modes held in the low bits of the mode register
   typedef enum logic [2:0] {
      SSM_SLEEP   = 3'b000,
      SSM_STANDBY = 3'b001,
      SSM_TX      = 3'b011,
      SSM_RX      = 3'b101
   } ssm_opmode_t;

   // bandwidth codes in the order 7.8 .. 500 khz
   localparam logic [3:0] BW_250K = 4'h8;
   localparam logic [3:0] BW_500K = 4'h9;

   // double sideband bandwidth in hz per code, scaled by 10
   localparam logic [22:0] BW_HZ10 [10] = '{23'd78000, 23'd104000, 23'd156000, 23'd208000,
      23'd312000, 23'd417000, 23'd625000, 23'd1250000, 23'd2500000, 23'd5000000};

   typedef struct packed {
      logic [3:0] sf;
      logic [3:0] bw;
      logic [2:0] cr;
      logic       implicit_hdr;
      logic       cr_in_hdr;
   } ssm_cfg_t;

endpackage

// [verilog/ssm_param_config.sv]
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module ssm_param_config
   import ssm_pkg::*;
#(
   parameter int FIFO_DEPTH = 256
) (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // modem side
   output logic             spread_mode,
   output ssm_cfg_t         modem_cfg,
   output logic [12:0]      chips_per_symbol,
   output logic [3:0]       overhead_x4,
   output logic [22:0]      symbol_rate_hz10,
   output logic             run_tx,
   output logic             run_rx,
   output logic             cfg_bad
);

   localparam int AW = $clog2(FIFO_DEPTH);

   // ===========================================
   // register state
   logic             modem_q;
   logic [2:0]       mode_q;
   logic [3:0]       sf_q;
   logic [3:0]       bw_q;
   logic [2:0]       cr_q;
   logic             impl_q;
   logic             crhdr_q;
   logic [2:0]       dettune_q;
   logic [7:0]       detthresh_q;
   logic [7:0]       fsk_cfg_q;
   logic [7:0]       fifo_mem_q [FIFO_DEPTH];
   logic [AW-1:0]    fifo_ptr_q;
   logic [31:0]      prdata_q;
   logic             pslverr_q;

   // ===========================================
   // bus decode
   wire access  = psel & penable;
   wire wr      = access & pwrite;
   wire rd      = access & ~pwrite;
   wire in_sleep = (mode_q == SSM_SLEEP);
   // the modem pages share addresses, so fsk setup shadows the spread map
   wire hit_opm  = (paddr == ADDR_OPMODE);
   wire hit_mod  = modem_q && (paddr == ADDR_MODCFG);
   wire hit_fsk  = !modem_q && (paddr == ADDR_FSK_CFG);
   wire hit_tx   = modem_q && (paddr == ADDR_TXCFG);
   wire hit_dtu  = modem_q && (paddr == ADDR_DETTUNE);
   wire hit_dth  = modem_q && (paddr == ADDR_DETTHRESH);
   wire hit_sts  = modem_q && (paddr == ADDR_STATUS);
   wire hit_fd   = modem_q && (paddr == ADDR_FIFO_DATA);
   wire hit_fp   = modem_q && (paddr == ADDR_FIFO_PTR);
   wire hit_any  = hit_opm | hit_mod | hit_fsk | hit_tx | hit_dtu | hit_dth
                   | hit_sts | hit_fd | hit_fp;

   // ===========================================
   // parameter checks
   wire sf_ok = (sf_q >= SF_MIN) && (sf_q <= SF_MAX);
   wire cr_ok = (cr_q >= CR_MIN) && (cr_q <= CR_MAX);
   wire bw_ok = (bw_q <= BW_MAX);
   wire sf6_ok = (sf_q != SF_MIN) || impl_q;
   wire bad   = !(sf_ok && cr_ok && bw_ok && sf6_ok);
   wire [2:0] new_mode = pwdata[OPM_MODE_LSB +: 3];
   // in spread mode a bad setup drops a tx/rx request to standby
   wire start_req = (new_mode == SSM_TX) || (new_mode == SSM_RX);
   wire [2:0] mode_acc = (start_req && modem_q && bad) ? SSM_STANDBY : new_mode;

   wire [31:0] rd_mux =
      hit_opm ? {24'h0, modem_q, 4'h0, mode_q} :
      hit_mod ? {24'h0, sf_q, bw_q} :
      hit_fsk ? {24'h0, fsk_cfg_q} :
      hit_tx  ? {27'h0, crhdr_q, cr_q, impl_q} :
      hit_dtu ? {29'h0, dettune_q} :
      hit_dth ? {24'h0, detthresh_q} :
      hit_sts ? {29'h0, sf6_ok, cr_ok, sf_ok} :
      hit_fd  ? {24'h0, fifo_mem_q[fifo_ptr_q]} :
      hit_fp  ? {{(32-AW){1'b0}}, fifo_ptr_q} :
      32'h0;

   // ===========================================
   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_q     <= 1'b0;
         mode_q      <= OPM_MODE_RST;
         sf_q        <= SF_RST;
         bw_q        <= BW_RST;
         cr_q        <= CR_RST;
         impl_q      <= 1'b0;
         crhdr_q     <= 1'b0;
         dettune_q   <= DETTUNE_RST;
         detthresh_q <= DETTHRESH_RST;
         fsk_cfg_q   <= FSK_CFG_RST;
      end else if (wr) begin
         if (hit_opm) begin
            mode_q <= mode_acc;
            // modem swap honoured only while asleep now and after
            if (in_sleep && new_mode == SSM_SLEEP) begin
               modem_q <= pwdata[OPM_MODEM_BIT];
            end
         end
         if (hit_mod) begin
            sf_q <= pwdata[MOD_SF_LSB +: 4];
            bw_q <= pwdata[MOD_BW_LSB +: 4];
         end
         if (hit_fsk) fsk_cfg_q <= pwdata[7:0];
         if (hit_tx) begin
            cr_q    <= pwdata[TX_CR_LSB +: 3];
            impl_q  <= pwdata[TX_IMPL_BIT];
            crhdr_q <= pwdata[TX_CRHDR_BIT];
         end
         if (hit_dtu) dettune_q <= pwdata[2:0];
         if (hit_dth) detthresh_q <= pwdata[7:0];
      end
   end

   // ===========================================
   // data buffer: pointer auto-increments on each data access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_ptr_q <= '0;
      end else if (access && hit_fp && pwrite) begin
         fifo_ptr_q <= pwdata[AW-1:0];
      end else if (access && hit_fd) begin
         fifo_ptr_q <= fifo_ptr_q + 1'b1;
      end
   end

   // storage has no reset; contents are undefined until written
   always_ff @(posedge pclk) begin
      if (wr && hit_fd) fifo_mem_q[fifo_ptr_q] <= pwdata[7:0];
   end

   // ===========================================
   // apb answer: zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         prdata_q  <= pwrite ? 32'h0 : rd_mux;
         pslverr_q <= !hit_any;
      end
   end
   assign prdata  = prdata_q;
   // registered in setup; only meaningful while the access phase stands
   assign pslverr = pslverr_q;
   assign pready  = 1'b1;

   // ===========================================
   // derived modem parameters
   logic        spread_q;
   ssm_cfg_t    cfg_q;
   logic [12:0] chips_q;
   logic [3:0]  ovh_q;
   logic [22:0] rate_q;
   logic        run_tx_q;
   logic        run_rx_q;
   logic        bad_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spread_q <= 1'b0;
         cfg_q    <= '0;
         chips_q  <= 13'h0;
         ovh_q    <= 4'h0;
         rate_q   <= 23'h0;
         run_tx_q <= 1'b0;
         run_rx_q <= 1'b0;
         bad_q    <= 1'b0;
      end else begin
         spread_q <= modem_q;
         cfg_q    <= '{sf: sf_q, bw: bw_q, cr: cr_q, implicit_hdr: impl_q, cr_in_hdr: crhdr_q};
         chips_q  <= sf_ok ? (13'h1 << sf_q) : 13'h0;
         ovh_q    <= cr_ok ? (4'h4 + {1'b0, cr_q}) : 4'h0;
         rate_q   <= (sf_ok && bw_ok) ? (BW_HZ10[bw_q] >> sf_q) : 23'h0;
         run_tx_q <= modem_q && !bad && (mode_q == SSM_TX);
         run_rx_q <= modem_q && !bad && (mode_q == SSM_RX);
         bad_q    <= bad;
      end
   end

   assign spread_mode      = spread_q;
   assign modem_cfg        = cfg_q;
   assign chips_per_symbol = chips_q;
   assign overhead_x4      = ovh_q;
   assign symbol_rate_hz10 = rate_q;
   assign run_tx           = run_tx_q;
   assign run_rx           = run_rx_q;
   assign cfg_bad          = bad_q;

   // ===========================================
   // checks
   property p_modem_sleep;
      @(posedge pclk) disable iff (!presetn)
      $changed(modem_q) |-> $past(mode_q) == SSM_SLEEP;
   endproperty
   a_modem_sleep: assert property (p_modem_sleep) else $error("modem changed out of sleep");

   property p_chips;
      @(posedge pclk) disable iff (!presetn)
      (sf_q == 4'hc) ##1 (sf_q == 4'hc) |-> chips_per_symbol == 13'd4096;
   endproperty
   a_chips: assert property (p_chips) else $error("sf12 chips wrong");

   property p_no_run_bad;
      @(posedge pclk) disable iff (!presetn)
      bad |=> !run_tx && !run_rx;
   endproperty
   a_no_run_bad: assert property (p_no_run_bad) else $error("ran with bad setup");

   property p_overhead;
      @(posedge pclk) disable iff (!presetn)
      (cr_q == 3'h4) |=> overhead_x4 == 4'h8;
   endproperty
   a_overhead: assert property (p_overhead) else $error("4/8 overhead wrong");

   property p_rate;
      @(posedge pclk) disable iff (!presetn)
      (sf_q == 4'h7 && bw_q == 4'h7) |=> symbol_rate_hz10 == 23'd9765;
   endproperty
   a_rate: assert property (p_rate) else $error("symbol rate wrong");

   property p_remap;
      @(posedge pclk) disable iff (!presetn)
      (rd && !modem_q && paddr == ADDR_DETTUNE) |-> pslverr;
   endproperty
   a_remap: assert property (p_remap) else $error("spread page seen in fsk map");

   property p_sf6_impl;
      @(posedge pclk) disable iff (!presetn)
      (sf_q == 4'h6 && !impl_q) |=> cfg_bad;
   endproperty
   a_sf6_impl: assert property (p_sf6_impl) else $error("sf6 explicit not flagged");

   property p_ptr_inc;
      @(posedge pclk) disable iff (!presetn)
      (access && hit_fd) |=> fifo_ptr_q == $past(fifo_ptr_q) + 1'b1;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("buffer pointer stuck");

endmodule

// [verif/ssm_host_model.sv]
`timescale 1ns/10ps
module ssm_host_model
   import ssm_pkg::*;
#(
   parameter bit LOW_BAND = 1'b0
) (
   // clock and answer
   input  wire logic        pclk,
   input  wire logic        pready,
   // request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
   end

   // ==========================================
   // one apb transfer, held until pready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // ==========================================
   // modem swap goes through sleep first
   task automatic to_spread();
      xfer(1'b1, ADDR_OPMODE, {24'h0, 1'b0, 4'h0, SSM_SLEEP});
      xfer(1'b1, ADDR_OPMODE, {24'h0, 1'b1, 4'h0, SSM_SLEEP});
   endtask

   // caller passes the sf agreed with the remote end
   task automatic set_sf(input logic [3:0] sf, input logic [3:0] bw);
      logic [3:0] bw_ok;
      bw_ok = (LOW_BAND && bw >= BW_250K) ? BW_RST : bw;
      xfer(1'b1, ADDR_TXCFG, {27'h0, 1'b0, CR_RST, sf == SF_MIN});
      xfer(1'b1, ADDR_MODCFG, {24'h0, sf, bw_ok});
      xfer(1'b1, ADDR_DETTUNE, {29'h0, (sf == SF_MIN) ? 3'b101 : DETTUNE_RST});
      xfer(1'b1, ADDR_DETTHRESH, {24'h0, (sf == SF_MIN) ? 8'h0c : DETTHRESH_RST});
   endtask
endmodule

// [verif/ssm_param_config_tb_top.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module ssm_param_config_tb_top;
   import ssm_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        spread_mode, run_tx, run_rx, cfg_bad, ok;
   logic [7:0]  paddr, b [3];
   logic [31:0] pwdata, prdata;
   logic [3:0]  sf, bw, overhead_x4;
   logic [12:0] chips_per_symbol;
   logic [22:0] symbol_rate_hz10;
   logic [32:0] e;
   ssm_cfg_t    modem_cfg;
   logic [32:0] q [$];
   int          err_count, checks, cyc, seed;

   ssm_param_config #(.FIFO_DEPTH(256)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .spread_mode(spread_mode), .modem_cfg(modem_cfg),
      .chips_per_symbol(chips_per_symbol), .overhead_x4(overhead_x4),
      .symbol_rate_hz10(symbol_rate_hz10), .run_tx(run_tx), .run_rx(run_rx), .cfg_bad(cfg_bad));
   ssm_host_model host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   always #20 pclk = ~pclk;

   // ==========================================
   // read notes: bit 32 set means an error answer, data ignored
   task automatic rd(input logic [7:0] a, input logic [32:0] x);
      q.push_back(x);
      host.xfer(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d);
   endtask
   task automatic settle();
      repeat (3) @(posedge pclk);
      #1;
   endtask
   task automatic close_out();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ==========================================
   // answer watcher
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && q.size() > 0) begin
         e = q.pop_front();
         if (e[32]) `CHK(pslverr, 1'b1)
         else `CHK({pslverr, prdata}, e)
      end
   end

   // hang guard, run needs well under 2000 cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      seed = 79;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_OPMODE, 33'h1);
      rd(ADDR_FSK_CFG, 33'h0);
      rd(ADDR_TXCFG, {1'b1, 32'h0});
      rd(ADDR_DETTUNE, {1'b1, 32'h0});
      wr(ADDR_OPMODE, 32'h81);
      rd(ADDR_OPMODE, 33'h1);
      host.to_spread();
      settle();
      `CHK(spread_mode, 1'b1)
      rd(ADDR_MODCFG, 33'h77);
      rd(ADDR_DETTHRESH, 33'h0a);
      for (int i = 0; i < 10; i++) begin
         sf = 4'(5 + i);
         bw = 4'(i);
         host.set_sf(sf, bw);
         settle();
         ok = (sf >= SF_MIN) && (sf <= SF_MAX);
         `CHK(chips_per_symbol, ok ? 13'(1 << sf) : 13'h0)
         `CHK(symbol_rate_hz10, ok ? 23'(BW_HZ10[bw] >> sf) : 23'h0)
         `CHK(cfg_bad, !ok)
         `CHK(modem_cfg.implicit_hdr, sf == SF_MIN)
         `CHK(modem_cfg.sf, sf)
         `CHK(modem_cfg.bw, bw)
         rd(ADDR_DETTUNE, {30'h0, (sf == SF_MIN) ? 3'b101 : DETTUNE_RST});
         rd(ADDR_DETTHRESH, {25'h0, (sf == SF_MIN) ? 8'h0c : DETTHRESH_RST});
      end
      host.set_sf(4'h7, 4'(($random(seed) & 32'h7fff) % 10));
      for (int c = 0; c < 6; c++) begin
         wr(ADDR_TXCFG, {27'h0, 1'b1, 3'(c), 1'b0});
         settle();
         `CHK(overhead_x4, (c >= 1 && c <= 4) ? 4'(4 + c) : 4'h0)
         `CHK(modem_cfg.cr_in_hdr, 1'b1)
         `CHK(modem_cfg.cr, 3'(c))
      end
      wr(ADDR_TXCFG, 32'h02);
      // sf6 with an explicit header must be flagged
      wr(ADDR_MODCFG, 32'h67);
      settle();
      `CHK(cfg_bad, 1'b1)
      wr(ADDR_MODCFG, 32'h77);
      wr(ADDR_OPMODE, 32'h83);
      settle();
      `CHK(run_tx, 1'b1)
      wr(ADDR_OPMODE, 32'h85);
      settle();
      `CHK({run_rx, run_tx}, 2'b10)
      wr(ADDR_OPMODE, 32'h80);
      wr(ADDR_TXCFG, 32'h0);
      wr(ADDR_OPMODE, 32'h83);
      rd(ADDR_OPMODE, 33'h81);
      rd(ADDR_STATUS, 33'h5);
      settle();
      `CHK({cfg_bad, run_tx}, 2'b10)
      wr(ADDR_FIFO_PTR, 32'h0);
      for (int i = 0; i < 3; i++) begin
         b[i] = 8'($random(seed));
         wr(ADDR_FIFO_DATA, {24'h0, b[i]});
      end
      wr(ADDR_FIFO_PTR, 32'h0);
      for (int i = 0; i < 3; i++) rd(ADDR_FIFO_DATA, {25'h0, b[i]});
      settle();
      `CHK(q.size(), 0)
      close_out();
   end
endmodule
